// *** include/cso_pkg.sv ***
`default_nettype none

package cso_pkg;

   // Output population and channel count.
   localparam int CSO_NUM_CLK = 8;
   localparam int CSO_NUM_REF = 7;
   localparam int CSO_NUM_OUT = 15;
   localparam int CSO_NUM_CHAN = 5;
   localparam int CSO_CHAN_E = 4;

   // Register byte addresses.
   localparam logic [11:0] CSO_ADDR_CTRL = 12'h000;
   localparam logic [11:0] CSO_ADDR_FUNC = 12'h004;
   localparam logic [11:0] CSO_ADDR_STATUS = 12'h008;
   localparam logic [11:0] CSO_ADDR_STATE = 12'h00c;
   localparam logic [11:0] CSO_ADDR_CHAN_BASE = 12'h020;
   localparam logic [11:0] CSO_ADDR_OUT_BASE = 12'h040;

   // Field positions.
   localparam int CSO_CTRL_TRIG_BIT = 0;
   localparam int CSO_CHAN_PD_BIT = 8;
   localparam int CSO_OUT_SRPH_LSB = 5;

   // Values after reset.
   localparam logic [6:0] CSO_FUNC_RST = 7'h00;
   localparam logic [8:0] CSO_CHAN_RST = 9'h000;
   localparam logic [7:0] CSO_OUT_RST = 8'h09;

   // Resolved state of one output.
   typedef enum logic [1:0] {
      CSO_OFF = 2'b00,
      CSO_LOW = 2'b01,
      CSO_ON = 2'b10
   } cso_state_type;

   // Sequencer states of a SYSREF event.
   typedef enum logic [0:0] {
      CSO_SR_IDLE = 1'b0,
      CSO_SR_EVENT = 1'b1
   } cso_seq_type;

   // Individual settings of one output.
   typedef struct packed {
      logic [2:0] sysref_phase;
      logic [1:0] swing;
      logic en;
      logic style;
      logic pd;
   } cso_out_cfg_type;

   // What one output stage is told to do.
   typedef struct packed {
      cso_state_type state;
      logic style;
      logic [1:0] swing;
      logic div_sysref;
      logic [7:0] phase;
   } cso_drive_type;

   // Channel that owns output i: clocks 0..7, references 8..14.
   function automatic logic [2:0] out_chan(input int i);
      logic [2:0] ch;
      case (i)
         0, 1, 8, 9, 10: ch = 3'd0;
         2, 3, 11, 12: ch = 3'd1;
         4, 13: ch = 3'd2;
         5, 14: ch = 3'd3;
         default: ch = 3'd4;
      endcase
      return ch;
   endfunction

endpackage

`default_nettype wire

// *** logic/cso_out_resolve.sv ***
`default_nettype none

module cso_out_resolve (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic chan_pd,
   input wire logic sel_sysref,
   input wire cso_pkg::cso_out_cfg_type cfg,
   input wire logic [7:0] clk_phase,
   input wire logic sysref_on,
   output cso_pkg::cso_drive_type drive
);

   cso_pkg::cso_state_type next_state;
   cso_pkg::cso_drive_type next_drive;

   // SYSREF duty hands the on/off state to the sequencer; clock duty uses own bits.
   assign next_state = chan_pd ? cso_pkg::CSO_OFF :
                       sel_sysref ? (sysref_on ? cso_pkg::CSO_ON : cso_pkg::CSO_LOW) :
                       cfg.pd ? cso_pkg::CSO_OFF :
                       !cfg.en ? cso_pkg::CSO_LOW : cso_pkg::CSO_ON;

   // Divider and phase source follow the function select.
   assign next_drive.state = next_state;
   // SYSREF duty is LVDS only, so the style bit counts in clock duty alone.
   assign next_drive.style = sel_sysref ? 1'b0 : cfg.style;
   assign next_drive.swing = cfg.swing;
   assign next_drive.div_sysref = sel_sysref;
   assign next_drive.phase = sel_sysref ? {5'h00, cfg.sysref_phase} : clk_phase;

   // Output register.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         drive <= '{state: cso_pkg::CSO_OFF, default: '0};
      end else begin
         drive <= next_drive;
      end
   end

   AST_SYSREF_ON: assert property (@(posedge clk) disable iff (!rst_b)
      sel_sysref && !chan_pd && sysref_on |=> drive.state == cso_pkg::CSO_ON)
      else $error("SYSREF duty output not on during event.");

   AST_SYSREF_OFF_AFTER: assert property (@(posedge clk) disable iff (!rst_b)
      sel_sysref && !chan_pd && !sysref_on |=> drive.state == cso_pkg::CSO_LOW)
      else $error("SYSREF duty output not static low outside event.");

   AST_CLK_PD: assert property (@(posedge clk) disable iff (!rst_b)
      !sel_sysref && cfg.pd |=> drive.state == cso_pkg::CSO_OFF)
      else $error("Powered-down output not off.");

   AST_CLK_EN: assert property (@(posedge clk) disable iff (!rst_b)
      !sel_sysref && !chan_pd && !cfg.pd |=> drive.state == ($past(cfg.en) ?
         cso_pkg::CSO_ON : cso_pkg::CSO_LOW))
      else $error("Clock duty output ignores its enable.");

   AST_DIV_SEL: assert property (@(posedge clk) disable iff (!rst_b)
      ##1 drive.div_sysref == $past(sel_sysref))
      else $error("Divider source does not follow function select.");

   AST_PHASE_SEL: assert property (@(posedge clk) disable iff (!rst_b)
      !sel_sysref ##1 !$stable(clk_phase) |=> drive.phase == $past(clk_phase) ||
         $past(sel_sysref))
      else $error("Clock duty output does not follow channel phase.");

   AST_SWING: assert property (@(posedge clk) disable iff (!rst_b)
      !sel_sysref |=> drive.swing == $past(cfg.swing) && drive.style == $past(cfg.style))
      else $error("Clock duty output ignores its swing or style.");

   AST_SYSREF_STYLE: assert property (@(posedge clk) disable iff (!rst_b)
      sel_sysref |=> drive.style == 1'b0)
      else $error("SYSREF duty output left the LVDS style.");

endmodule

`default_nettype wire

// *** logic/cso_channel_ctrl.sv ***
// The register addresses and register access over APB were left to the implementer.
`default_nettype none

module cso_channel_ctrl (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sysref_begin,
   input wire logic sysref_end,
   output logic sysref_request,
   output cso_pkg::cso_drive_type [cso_pkg::CSO_NUM_OUT-1:0] out_drive
);

   logic [6:0] func_sel;
   logic [8:0] chan_cfg [cso_pkg::CSO_NUM_CHAN];
   logic [7:0] out_cfg [cso_pkg::CSO_NUM_OUT];
   cso_pkg::cso_seq_type seq;
   cso_pkg::cso_seq_type next_seq;
   logic [31:0] next_prdata;
   logic [cso_pkg::CSO_NUM_OUT-1:0] out_sel;
   logic [2*cso_pkg::CSO_NUM_OUT-1:0] state_vec;

   // Address decode of the APB setup and access phases.
   wire setup_ph = psel && !penable;
   wire access_ph = psel && penable;
   wire aligned = paddr[1:0] == 2'b00;
   wire [2:0] chan_idx = paddr[4:2];
   wire [3:0] out_idx = paddr[5:2];
   wire hit_ctrl = paddr == cso_pkg::CSO_ADDR_CTRL;
   wire hit_func = paddr == cso_pkg::CSO_ADDR_FUNC;
   wire hit_status = paddr == cso_pkg::CSO_ADDR_STATUS;
   wire hit_state = paddr == cso_pkg::CSO_ADDR_STATE;
   wire hit_chan = aligned && paddr[11:5] == cso_pkg::CSO_ADDR_CHAN_BASE[11:5] &&
                   chan_idx < 3'(cso_pkg::CSO_NUM_CHAN);
   wire hit_out = aligned && paddr[11:6] == cso_pkg::CSO_ADDR_OUT_BASE[11:6] &&
                  out_idx < 4'(cso_pkg::CSO_NUM_OUT);
   wire addr_ok = hit_ctrl || hit_func || hit_status || hit_state || hit_chan || hit_out;
   wire wr_en = access_ph && pwrite && addr_ok;
   wire trig_wr = wr_en && hit_ctrl && pwdata[cso_pkg::CSO_CTRL_TRIG_BIT];
   wire sysref_on = seq == cso_pkg::CSO_SR_EVENT;
   wire chan_a_pd = chan_cfg[0][cso_pkg::CSO_CHAN_PD_BIT];
   wire ref_a0_sysref = func_sel[0] && !chan_a_pd;

   // Zero-wait slave; unmapped addresses answer with an error.
   assign pready = 1'b1;
   assign pslverr = access_ph && !addr_ok;

   // Clock outputs never take SYSREF duty; channel E has none.
   assign out_sel = {func_sel, 8'h00};

   // Read data selection.
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (hit_func) begin
         next_prdata = {25'h0000000, func_sel};
      end else if (hit_status) begin
         next_prdata = {31'h00000000, sysref_on};
      end else if (hit_state) begin
         next_prdata = {2'b00, state_vec};
      end else if (hit_chan) begin
         next_prdata = {23'h000000, chan_cfg[chan_idx]};
      end else if (hit_out) begin
         next_prdata = {24'h000000, out_cfg[out_idx]};
      end
   end

   // Read data register, loaded in the setup phase.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (setup_ph) begin
         prdata <= next_prdata;
      end
   end

   // Function-select bits, one per reference output.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         func_sel <= cso_pkg::CSO_FUNC_RST;
      end else if (wr_en && hit_func) begin
         func_sel <= pwdata[6:0];
      end
   end

   // Channel settings: clock phase and channel power-down.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int c = 0; c < cso_pkg::CSO_NUM_CHAN; c++) begin
            chan_cfg[c] <= cso_pkg::CSO_CHAN_RST;
         end
      end else if (wr_en && hit_chan) begin
         chan_cfg[chan_idx] <= pwdata[8:0];
      end
   end

   // Individual output settings.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int o = 0; o < cso_pkg::CSO_NUM_OUT; o++) begin
            out_cfg[o] <= cso_pkg::CSO_OUT_RST;
         end
      end else if (wr_en && hit_out) begin
         out_cfg[out_idx] <= pwdata[7:0];
      end
   end

   // Request pulse to the SYSREF pulse generator on a software trigger.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sysref_request <= 1'b0;
      end else begin
         sysref_request <= trig_wr;
      end
   end

   // SYSREF sequencer: on at the event start, off when the event completes.
   always_comb begin
      case (seq)
         cso_pkg::CSO_SR_IDLE: next_seq = sysref_begin ? cso_pkg::CSO_SR_EVENT : seq;
         cso_pkg::CSO_SR_EVENT: next_seq = sysref_end ? cso_pkg::CSO_SR_IDLE : seq;
         default: next_seq = cso_pkg::CSO_SR_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seq <= cso_pkg::CSO_SR_IDLE;
      end else begin
         seq <= next_seq;
      end
   end

   // One resolver per output, tied to its owning channel.
   for (genvar i = 0; i < cso_pkg::CSO_NUM_OUT; i++) begin : g_out
      localparam logic [2:0] CH = cso_pkg::out_chan(i);
      cso_out_resolve u_res (
         .clk(clk),
         .rst_b(rst_b),
         .chan_pd(chan_cfg[CH][cso_pkg::CSO_CHAN_PD_BIT]),
         .sel_sysref(out_sel[i]),
         .cfg(cso_pkg::cso_out_cfg_type'(out_cfg[i])),
         .clk_phase(chan_cfg[CH][7:0]),
         .sysref_on(sysref_on),
         .drive(out_drive[i])
      );
      assign state_vec[2*i+1:2*i] = out_drive[i].state;
   end

   AST_SEQ_START: assert property (@(posedge clk) disable iff (!rst_b)
      seq == cso_pkg::CSO_SR_IDLE && sysref_begin |=> seq == cso_pkg::CSO_SR_EVENT)
      else $error("SYSREF event did not start.");

   AST_SEQ_END: assert property (@(posedge clk) disable iff (!rst_b)
      seq == cso_pkg::CSO_SR_EVENT && sysref_end |=> seq == cso_pkg::CSO_SR_IDLE)
      else $error("SYSREF event did not end on completion.");

   AST_CHAN_E_CLOCK: assert property (@(posedge clk) disable iff (!rst_b)
      !out_drive[6].div_sysref && !out_drive[7].div_sysref)
      else $error("Channel E output took SYSREF duty.");

   AST_FUNC_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
      wr_en && hit_func |=> func_sel == $past(pwdata[6:0]) ##1
      out_drive[8].div_sysref == $past(pwdata[0], 2))
      else $error("Function select write not applied per output.");

   AST_REF_ON_EVENT: assert property (@(posedge clk) disable iff (!rst_b)
      func_sel[0] && !chan_cfg[0][cso_pkg::CSO_CHAN_PD_BIT] && sysref_on &&
      $stable(func_sel) |=> out_drive[8].state == cso_pkg::CSO_ON)
      else $error("SYSREF duty reference not switched on by the sequencer.");

   // Channel-level checks on references A0 and A1, clock output A0, the request pulse and the register port.
   AST_REQ_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
      ##1 sysref_request == $past(trig_wr))
      else $error("SYSREF request pulse does not follow the trigger write.");

   AST_REF_OFF_AFTER_EVENT: assert property (@(posedge clk) disable iff (!rst_b)
      seq == cso_pkg::CSO_SR_EVENT && sysref_end && ref_a0_sysref ##1 ref_a0_sysref |=>
      out_drive[8].state == cso_pkg::CSO_LOW)
      else $error("SYSREF duty reference not released to static low after the event.");

   AST_REF_PD_IGNORED: assert property (@(posedge clk) disable iff (!rst_b)
      ref_a0_sysref && out_cfg[8][0] && !sysref_on |=>
      out_drive[8].state == cso_pkg::CSO_LOW)
      else $error("SYSREF duty reference obeyed its own power-down.");

   AST_CHAN_PD_OFF: assert property (@(posedge clk) disable iff (!rst_b)
      chan_a_pd |=> out_drive[0].state == cso_pkg::CSO_OFF &&
      out_drive[8].state == cso_pkg::CSO_OFF)
      else $error("Channel power-down left an output of channel A on.");

   AST_REF_INDEPENDENT: assert property (@(posedge clk) disable iff (!rst_b)
      wr_en && hit_func |=> ##1 out_drive[9].div_sysref == $past(pwdata[1], 2))
      else $error("Function select of reference A1 not applied on its own.");

   AST_CLK_PHASE_A: assert property (@(posedge clk) disable iff (!rst_b)
      ##1 out_drive[0].phase == $past(chan_cfg[0][7:0]))
      else $error("Clock output A0 does not follow the channel phase.");

   AST_STATUS_READ: assert property (@(posedge clk) disable iff (!rst_b)
      setup_ph && hit_status |=> prdata == {31'h00000000, $past(sysref_on)})
      else $error("Status read does not show the SYSREF event.");

   AST_REFUSED_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
      access_ph && pwrite && !addr_ok |=> $stable(func_sel) && $stable(out_cfg[8]))
      else $error("Write to an unmapped address changed a setting.");

endmodule

`default_nettype wire

// *** dv/cso_sysref_gen.sv ***
`default_nettype none

module cso_sysref_gen #(
   parameter int DLY = 2,
   parameter int LEN = 6
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sysref_request,
   output logic sysref_begin,
   output logic sysref_end
);
   timeunit 1ns;
   timeprecision 1ns;

   // Answers each request seen while idle with an event start pulse and, later, an end pulse.
   initial begin
      sysref_begin = 1'b0;
      sysref_end = 1'b0;
      forever begin
         @(posedge clk);
         if (rst_b && sysref_request) begin
            repeat (DLY) @(posedge clk);
            sysref_begin <= 1'b1;
            @(posedge clk);
            sysref_begin <= 1'b0;
            repeat (LEN) @(posedge clk);
            sysref_end <= 1'b1;
            @(posedge clk);
            sysref_end <= 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

// *** dv/cso_channel_ctrl_bench.sv ***
`default_nettype none

module cso_channel_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sysref_begin;
   logic sysref_end;
   logic sysref_request;
   cso_pkg::cso_drive_type [cso_pkg::CSO_NUM_OUT-1:0] out_drive;
   int fails = 0;
   int cmp_count = 0;
   logic [31:0] rd;
   logic er;

   // The clock toggles every half period of 20 ns, a period of 40 ns.
   always #20 clk = ~clk;

   cso_channel_ctrl u_cso_channel_ctrl (.clk(clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sysref_begin(sysref_begin),
      .sysref_end(sysref_end), .sysref_request(sysref_request), .out_drive(out_drive));

   cso_sysref_gen u_cso_sysref_gen (.clk(clk), .rst_b(rst_b),
      .sysref_request(sysref_request), .sysref_begin(sysref_begin), .sysref_end(sysref_end));

   // Compares one value and counts the outcome.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready is seen high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // Expected drive word built from its fields.
   function automatic logic [31:0] dv(input logic [1:0] st, input logic sty,
      input logic [1:0] sw, input logic ds, input logic [7:0] ph);
      return {18'h0, st, sty, sw, ds, ph};
   endfunction

   // Waits a bounded time for output 8 to reach a state.
   task automatic wait_state(input logic [1:0] st);
      int n;
      n = 0;
      while (out_drive[8].state !== st && n < 40) begin
         @(posedge clk);
         n++;
      end
   endtask

   // Lets one edge pass so that registered outputs have settled.
   task automatic tick;
      @(posedge clk);
   endtask

   // Register defaults and a refused access.
   task automatic t_reset_map;
      apb(1'b0, cso_pkg::CSO_ADDR_OUT_BASE, 32'h0);
      chk(rd, 32'(cso_pkg::CSO_OUT_RST));
      chk(32'(out_drive[0].state), 32'(cso_pkg::CSO_OFF));
      apb(1'b1, 12'h100, 32'hff);
      chk(32'(er), 32'h1);
   endtask

   // Clock output and clock-duty reference follow their own settings.
   task automatic t_clock_duty;
      apb(1'b1, cso_pkg::CSO_ADDR_CHAN_BASE, 32'h5a);
      apb(1'b1, cso_pkg::CSO_ADDR_OUT_BASE, 32'h16);
      apb(1'b1, cso_pkg::CSO_ADDR_OUT_BASE + 12'h020, 32'hbc);
      tick();
      chk(32'(out_drive[0]), dv(2'b10, 1'b1, 2'b10, 1'b0, 8'h5a));
      chk(32'(out_drive[8]), dv(2'b10, 1'b0, 2'b11, 1'b0, 8'h5a));
      chk(32'(out_drive[9].state), 32'(cso_pkg::CSO_OFF));
      apb(1'b1, cso_pkg::CSO_ADDR_OUT_BASE + 12'h020, 32'hb8);
      tick();
      chk(32'(out_drive[8].state), 32'(cso_pkg::CSO_LOW));
      apb(1'b1, cso_pkg::CSO_ADDR_OUT_BASE + 12'h020, 32'hbd);
      tick();
      chk(32'(out_drive[8].state), 32'(cso_pkg::CSO_OFF));
   endtask

   // SYSREF duty: shared divider, own phase, automatic on and off.
   task automatic t_sysref_duty;
      apb(1'b1, cso_pkg::CSO_ADDR_OUT_BASE + 12'h020, 32'hab);
      apb(1'b1, cso_pkg::CSO_ADDR_FUNC, 32'h1);
      tick();
      chk(32'(out_drive[8]), dv(2'b01, 1'b0, 2'b01, 1'b1, 8'h05));
      chk(32'(out_drive[8].div_sysref), 32'h1);
      chk(32'(out_drive[8].phase), 32'h5);
      chk(32'(out_drive[0].div_sysref), 32'h0);
      apb(1'b1, cso_pkg::CSO_ADDR_CTRL, 32'h1);
      chk(32'(sysref_request), 32'h1);
      wait_state(cso_pkg::CSO_ON);
      chk(32'(out_drive[8].state), 32'(cso_pkg::CSO_ON));
      apb(1'b0, cso_pkg::CSO_ADDR_STATUS, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, cso_pkg::CSO_ADDR_STATE, 32'h0);
      chk(32'(rd[17:16]), 32'(cso_pkg::CSO_ON));
      chk(32'(out_drive[9].state), 32'(cso_pkg::CSO_OFF));
      wait_state(cso_pkg::CSO_LOW);
      chk(32'(out_drive[8].state), 32'(cso_pkg::CSO_LOW));
      apb(1'b0, cso_pkg::CSO_ADDR_STATUS, 32'h0);
      chk(rd, 32'h0);
   endtask

   // Channel E has no function-select bit.
   task automatic t_chan_e;
      apb(1'b1, cso_pkg::CSO_ADDR_FUNC, 32'hff);
      apb(1'b0, cso_pkg::CSO_ADDR_FUNC, 32'h0);
      chk(rd, 32'h7f);
      chk(32'({out_drive[7].div_sysref, out_drive[6].div_sysref}), 32'h0);
      apb(1'b1, cso_pkg::CSO_ADDR_CHAN_BASE, 32'h15a);
      tick();
      chk(32'(out_drive[8].state), 32'(cso_pkg::CSO_OFF));
      chk(32'(out_drive[0].state), 32'(cso_pkg::CSO_OFF));
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done;
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Main sequence after a reset of 16 cycles.
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset_map();
      t_clock_duty();
      t_sysref_duty();
      t_chan_e();
      test_done();
   end

   // Cuts a hang short well after the tests should have ended.
   initial begin
      #400000;
      fails++;
      test_done();
   end
endmodule

`default_nettype wire
